// >>> core/spi_front_end.v
`timescale 1ns/1ps
`default_nettype none
`include "spi_front_defs.vh"

// Summary of operation
// - Select high: deselected, every lane output enable low.
// - Select low: accept opcode bytes and return read data.
// - No opcode accepted after reset until a select falling edge is seen.
// - Single lane: bits sampled from lane zero on rising clock edges.
// - Single lane: read data shifted out on lane one at falling edges.
// - Dual/quad: lanes captured on rising edges, driven on falling edges.
// - Modes 0 and 3 supported; clock level at select edges is ignored.
// - Dual read opcodes turn lanes zero and one bidirectional.
// - Quad read and quad load opcodes use all four lanes.
// - Opcode byte always latched on rising edges only.
// - Double-edge reads take address and drive data on both edges.
// - Quad enable set disables the write-guard pin function.
// - Guard enable clear: low guard pin protects only protection register, and only with status guard field bit 0 set.
// - Guard enable set and pin low: block every write, program, erase.
// - Guard enable set: quad reads rejected.
// - Block guard field alone selects protected region code; status guard field and guard pin only gate writes.
// - Pause low while selected in single/dual with quad enable clear and no double-edge: float output, ignore inputs.
// - Hardware reset pin overrides every other interface input.
// - Reset pin low at least about 1 us returns to power-on state.
// - Pause starts/ends at pin edge if clock low, else next falling edge.
module spi_front_end #(
   parameter RESET_MIN_CYC = `HW_RESET_PULSE_MIN_CYC
) (
   input wire clock,
   input wire sys_rst,
   input wire sclk_pin,
   input wire select_n_pin,
   input wire hw_reset_n_pin,
   input wire lane_zero_in,
   output reg lane_zero_out,
   output reg lane_zero_oe,
   input wire lane_one_in,
   output reg lane_one_out,
   output reg lane_one_oe,
   input wire lane_two_in,
   output reg lane_two_out,
   output reg lane_two_oe,
   input wire lane_three_in,
   output reg lane_three_out,
   output reg lane_three_oe,
   input wire quad_lane_enable_bit,
   input wire guard_enable_bit,
   input wire dtr_enable_bit,
   input wire [3:0] block_guard_field,
   input wire [1:0] status_guard_field,
   input wire [7:0] read_data,
   output reg read_data_take,
   output reg [7:0] opcode,
   output reg opcode_valid,
   output reg [7:0] rx_byte,
   output reg rx_byte_valid,
   output reg quad_rejected,
   output reg [3:0] protected_blocks_code,
   output reg array_write_block,
   output reg prot_reg_write_block,
   output reg paused,
   output reg in_reset
);
   localparam ST_IDLE = 4'b0001;
   localparam ST_OPC = 4'b0010;
   localparam ST_ADDR = 4'b0100;
   localparam ST_DATA = 4'b1000;

   wire [6:0] sync_q;
   // Start from the idle pin levels so reset release shows no false edge
   pin_sync #(.W(7), .INIT(7'h6f)) u_sync (
      .clock(clock),
      .sys_rst(sys_rst),
      .async_in({hw_reset_n_pin, select_n_pin, sclk_pin, lane_three_in, lane_two_in, lane_one_in, lane_zero_in}),
      .sync_out(sync_q)
   );
   wire rst_n_s = sync_q[6];
   wire sel_n_s = sync_q[5];
   wire sck_s = sync_q[4];
   wire [3:0] lane_s = sync_q[3:0];

   // Width of a transfer: 1, 2 or 4 lanes
   function [2:0] lanes_of;
      input [7:0] op;
      begin
         case (op)
            `OP_DUAL_OUT, `OP_DUAL_IO, `OP_DTR_DUAL_OUT, `OP_DTR_DUAL_IO: lanes_of = 3'd2;
            `OP_QUAD_OUT, `OP_QUAD_IO, `OP_DTR_QUAD_OUT, `OP_DTR_QUAD_IO,
            `OP_QUAD_LOAD_A, `OP_QUAD_LOAD_B: lanes_of = 3'd4;
            default: lanes_of = 3'd1;
         endcase
      end
   endfunction

   function is_dtr;
      input [7:0] op;
      begin
         is_dtr = (op == `OP_DTR_DUAL_OUT) || (op == `OP_DTR_DUAL_IO) ||
                  (op == `OP_DTR_QUAD_OUT) || (op == `OP_DTR_QUAD_IO);
      end
   endfunction

   function is_read;
      input [7:0] op;
      begin
         is_read = (op != `OP_QUAD_LOAD_A) && (op != `OP_QUAD_LOAD_B);
      end
   endfunction

   reg sck_d_r;
   reg sel_n_d_r;
   reg [3:0] state_r;
   reg armed_r;
   reg [7:0] shift_r;
   reg [3:0] bitcnt_r;
   reg [1:0] addr_cnt_r;
   reg [7:0] tx_r;
   reg [2:0] lanes_r;
   reg dtr_r;
   reg rd_r;
   reg hold_r;
   reg [15:0] rst_cnt_r;
   reg rst_act_r;

   wire sck_rise = sck_s & ~sck_d_r;
   wire sck_fall = ~sck_s & sck_d_r;
   wire sel_fall = ~sel_n_s & sel_n_d_r;
   wire sel_rise = sel_n_s & ~sel_n_d_r;
   // Pause pin only means something in single/dual without double-edge
   wire hold_avail = ~quad_lane_enable_bit & ~dtr_enable_bit & ~dtr_r & (lanes_r != 3'd4);
   wire hold_pin_low = hold_avail & ~lane_s[3];
   wire hold_nxt = hold_pin_low ? (~sck_s | sck_fall | hold_r) : (hold_r & sck_s & ~sck_fall);
   wire act = ~sel_n_s & ~rst_act_r & ~hold_r;
   wire in_edge = dtr_r && state_r == ST_ADDR ? (sck_rise | sck_fall) : sck_rise;
   wire out_edge = dtr_r ? (sck_rise | sck_fall) : sck_fall;

   reg [7:0] sh_nxt;
   reg [3:0] cnt_nxt;
   always @*
   begin
      sh_nxt = shift_r;
      cnt_nxt = bitcnt_r;
      case (lanes_r)
         3'd4:
         begin
            sh_nxt = {shift_r[3:0], lane_s};
            cnt_nxt = bitcnt_r + 4'd4;
         end
         3'd2:
         begin
            sh_nxt = {shift_r[5:0], lane_s[1:0]};
            cnt_nxt = bitcnt_r + 4'd2;
         end
         default:
         begin
            sh_nxt = {shift_r[6:0], lane_s[0]};
            cnt_nxt = bitcnt_r + 4'd1;
         end
      endcase
   end

   always @(posedge clock)
   begin
      if (sys_rst)
      begin
         sck_d_r <= 1'b0;
         sel_n_d_r <= 1'b1;
         state_r <= ST_IDLE;
         armed_r <= 1'b0;
         shift_r <= 8'h00;
         bitcnt_r <= 4'h0;
         addr_cnt_r <= 2'd0;
         tx_r <= 8'h00;
         lanes_r <= 3'd1;
         dtr_r <= 1'b0;
         rd_r <= 1'b0;
         hold_r <= 1'b0;
         rst_cnt_r <= 16'h0000;
         rst_act_r <= 1'b0;
         opcode <= 8'h00;
         opcode_valid <= 1'b0;
         rx_byte <= 8'h00;
         rx_byte_valid <= 1'b0;
         read_data_take <= 1'b0;
         quad_rejected <= 1'b0;
         paused <= 1'b0;
         in_reset <= 1'b0;
         {lane_zero_out, lane_one_out, lane_two_out, lane_three_out} <= 4'h0;
         {lane_zero_oe, lane_one_oe, lane_two_oe, lane_three_oe} <= 4'h0;
         protected_blocks_code <= 4'h0;
         array_write_block <= 1'b0;
         prot_reg_write_block <= 1'b0;
      end
      else
      begin
         sck_d_r <= sck_s;
         sel_n_d_r <= sel_n_s;
         opcode_valid <= 1'b0;
         rx_byte_valid <= 1'b0;
         read_data_take <= 1'b0;
         protected_blocks_code <= block_guard_field;
         // Guard pin inactive as such when it serves as lane two
         array_write_block <= guard_enable_bit & ~quad_lane_enable_bit & ~lane_s[2];
         prot_reg_write_block <= ~quad_lane_enable_bit & ~lane_s[2] &
                                 (guard_enable_bit | status_guard_field[0]);
         // Reset pin wins over everything; pulses shorter than the minimum are filtered
         if (!rst_n_s)
         begin
            if (rst_cnt_r != RESET_MIN_CYC[15:0])
               rst_cnt_r <= rst_cnt_r + 16'd1;
            else
               rst_act_r <= 1'b1;
         end
         else
            rst_cnt_r <= 16'h0000;
         if (rst_act_r)
         begin
            state_r <= ST_IDLE;
            armed_r <= 1'b0;
            hold_r <= 1'b0;
            dtr_r <= 1'b0;
            lanes_r <= 3'd1;
            in_reset <= 1'b1;
            paused <= 1'b0;
            quad_rejected <= 1'b0;
            {lane_zero_oe, lane_one_oe, lane_two_oe, lane_three_oe} <= 4'h0;
            if (rst_n_s)
               rst_act_r <= 1'b0;
         end
         else if (sel_n_s)
         begin
            in_reset <= 1'b0;
            // Deselect floats every lane and drops any partial instruction
            {lane_zero_oe, lane_one_oe, lane_two_oe, lane_three_oe} <= 4'h0;
            state_r <= ST_IDLE;
            hold_r <= 1'b0;
            paused <= 1'b0;
            lanes_r <= 3'd1;
            dtr_r <= 1'b0;
            bitcnt_r <= 4'h0;
            if (sel_rise)
               quad_rejected <= 1'b0;
         end
         else
         begin
            in_reset <= 1'b0;
            hold_r <= hold_nxt;
            paused <= hold_nxt;
            if (hold_r && hold_nxt)
               {lane_zero_oe, lane_one_oe, lane_two_oe, lane_three_oe} <= 4'h0;
            else if (hold_r && state_r == ST_DATA)
            begin
               // Resume drives the held bit again without waiting for a clock edge
               lane_one_oe <= 1'b1;
               lane_zero_oe <= (lanes_r == 3'd2);
            end
            if (sel_fall)
            begin
               armed_r <= 1'b1;
               state_r <= armed_r | 1'b1 ? ST_OPC : ST_IDLE;
               bitcnt_r <= 4'h0;
               lanes_r <= 3'd1;
            end
            else if (act)
            begin
               case (state_r)
                  ST_OPC:
                  begin
                     if (sck_rise)
                     begin
                        shift_r <= sh_nxt;
                        bitcnt_r <= cnt_nxt;
                        if (cnt_nxt == 4'd8)
                        begin
                           bitcnt_r <= 4'h0;
                           opcode <= sh_nxt;
                           opcode_valid <= 1'b1;
                           addr_cnt_r <= 2'd0;
                           rd_r <= is_read(sh_nxt);
                           if (guard_enable_bit && lanes_of(sh_nxt) == 3'd4 && is_read(sh_nxt))
                           begin
                              quad_rejected <= 1'b1;
                              state_r <= ST_IDLE;
                           end
                           else if (lanes_of(sh_nxt) == 3'd4 && !quad_lane_enable_bit)
                              state_r <= ST_IDLE;
                           else
                           begin
                              lanes_r <= lanes_of(sh_nxt);
                              dtr_r <= is_dtr(sh_nxt);
                              state_r <= ST_ADDR;
                           end
                        end
                     end
                  end
                  ST_ADDR:
                  begin
                     if (in_edge)
                     begin
                        shift_r <= sh_nxt;
                        bitcnt_r <= cnt_nxt;
                        if (cnt_nxt == 4'd8)
                        begin
                           bitcnt_r <= 4'h0;
                           rx_byte <= sh_nxt;
                           rx_byte_valid <= 1'b1;
                           addr_cnt_r <= addr_cnt_r + 2'd1;
                           if (addr_cnt_r == `ADDR_BYTES - 1 || !rd_r)
                           begin
                              state_r <= rd_r ? ST_DATA : ST_ADDR;
                              tx_r <= read_data;
                              read_data_take <= rd_r;
                           end
                        end
                     end
                  end
                  ST_DATA:
                  begin
                     if (out_edge)
                     begin
                        case (lanes_r)
                           3'd4:
                           begin
                              {lane_three_out, lane_two_out, lane_one_out, lane_zero_out} <= tx_r[7:4];
                              {lane_three_oe, lane_two_oe, lane_one_oe, lane_zero_oe} <= 4'hf;
                              tx_r <= {tx_r[3:0], 4'h0};
                           end
                           3'd2:
                           begin
                              {lane_one_out, lane_zero_out} <= tx_r[7:6];
                              {lane_one_oe, lane_zero_oe} <= 2'b11;
                              tx_r <= {tx_r[5:0], 2'b00};
                           end
                           default:
                           begin
                              lane_one_out <= tx_r[7];
                              lane_one_oe <= 1'b1;
                              tx_r <= {tx_r[6:0], 1'b0};
                           end
                        endcase
                        bitcnt_r <= cnt_nxt;
                        if (cnt_nxt == 4'd8)
                        begin
                           bitcnt_r <= 4'h0;
                           tx_r <= read_data;
                           read_data_take <= 1'b1;
                        end
                     end
                  end
                  default: state_r <= ST_IDLE;
               endcase
            end
         end
      end
   end
endmodule // spi_front_end
`default_nettype wire

// >>> core/spi_front_defs.vh
`ifndef SPI_FRONT_DEFS_VH
`define SPI_FRONT_DEFS_VH
`define CLK_PERIOD_NS 10
`define HW_RESET_PULSE_MIN_NS 1000
`define HW_RESET_PULSE_MIN_CYC ((`HW_RESET_PULSE_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define OP_DUAL_OUT 8'h3b
`define OP_DUAL_IO 8'hbb
`define OP_DTR_DUAL_OUT 8'h3d
`define OP_DTR_DUAL_IO 8'hbd
`define OP_QUAD_OUT 8'h6b
`define OP_QUAD_IO 8'heb
`define OP_DTR_QUAD_OUT 8'h6d
`define OP_DTR_QUAD_IO 8'hed
`define OP_QUAD_LOAD_A 8'h32
`define OP_QUAD_LOAD_B 8'h34
`define ADDR_BYTES 2
`endif

// >>> core/pin_sync.v
`timescale 1ns/1ps
`default_nettype none
// Two-flop synchroniser for a bundle of pin levels
module pin_sync #(
   parameter W = 1,
   parameter [W-1:0] INIT = {W{1'b0}}
) (
   input wire clock,
   input wire sys_rst,
   input wire [W-1:0] async_in,
   output reg [W-1:0] sync_out
);
   reg [W-1:0] meta_r;

   always @(posedge clock)
   begin
      if (sys_rst)
      begin
         meta_r <= INIT;
         sync_out <= INIT;
      end
      else
      begin
         meta_r <= async_in;
         sync_out <= meta_r;
      end
   end
endmodule // pin_sync
`default_nettype wire

// >>> testbench/spi_front_end_properties.sv
`timescale 1ns/1ps
`default_nettype none
module spi_front_end_checker (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic select_n_pin,
   input wire logic lane_two_in,
   input wire logic lane_zero_oe,
   input wire logic lane_one_oe,
   input wire logic lane_two_oe,
   input wire logic lane_three_oe,
   input wire logic quad_lane_enable_bit,
   input wire logic guard_enable_bit,
   input wire logic [1:0] status_guard_field,
   input wire logic opcode_valid,
   input wire logic quad_rejected,
   input wire logic array_write_block,
   input wire logic prot_reg_write_block,
   input wire logic paused,
   input wire logic in_reset
);
   wire logic any_oe = lane_zero_oe | lane_one_oe | lane_two_oe | lane_three_oe;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (sys_rst);
   // Pin levels pass a two-flop synchroniser, so levels must settle first
   property p_deselect_float;
      select_n_pin [*6] |-> !any_oe;
   endproperty
   a_deselect_float: assert property (p_deselect_float) else $error("lane driven while deselected");
   property p_array_block;
      (guard_enable_bit && !quad_lane_enable_bit && !lane_two_in) [*5] |-> array_write_block;
   endproperty
   a_array_block: assert property (p_array_block) else $error("array writes not blocked");
   property p_qe_frees;
      quad_lane_enable_bit [*2] |-> !array_write_block && !prot_reg_write_block;
   endproperty
   a_qe_frees: assert property (p_qe_frees) else $error("guard pin active with quad enable");
   property p_reg_block;
      (!quad_lane_enable_bit && !lane_two_in && (guard_enable_bit || status_guard_field[0])) [*5]
         |-> prot_reg_write_block;
   endproperty
   a_reg_block: assert property (p_reg_block) else $error("register writes not blocked");
   property p_opcode_gap;
      opcode_valid |=> !opcode_valid [*8];
   endproperty
   a_opcode_gap: assert property (p_opcode_gap) else $error("opcode pulses too close");
   property p_pause_float;
      paused [*2] |-> !lane_one_oe;
   endproperty
   a_pause_float: assert property (p_pause_float) else $error("output driven in pause");
   property p_quad_refuse;
      $rose(quad_rejected) |-> guard_enable_bit && !lane_two_oe && !lane_three_oe;
   endproperty
   a_quad_refuse: assert property (p_quad_refuse) else $error("quad refusal wrong");
   property p_reset_float;
      in_reset [*2] |-> !any_oe;
   endproperty
   a_reset_float: assert property (p_reset_float) else $error("lane driven in reset");
   c_opcode: cover property (opcode_valid);
   c_pause: cover property (paused);
   c_refuse: cover property (quad_rejected);
endmodule // spi_front_end_checker
bind spi_front_end spi_front_end_checker spi_front_end_checker_i (.clock, .sys_rst, .select_n_pin,
   .lane_two_in, .lane_zero_oe, .lane_one_oe, .lane_two_oe, .lane_three_oe, .quad_lane_enable_bit,
   .guard_enable_bit, .status_guard_field, .opcode_valid, .quad_rejected, .array_write_block,
   .prot_reg_write_block, .paused, .in_reset);
`default_nettype wire

// >>> testbench/host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model (
   input wire logic clock,
   output logic sclk,
   output logic select_n,
   output logic mosi,
   input wire logic miso
);
   // Half of a 160 ns serial clock period in system cycles
   localparam int HALF = 8;
   logic cpol_r;
   initial {sclk, select_n, mosi, cpol_r} = 4'b0100;
   task automatic start(input logic cpol);
   begin
      @(posedge clock);
      cpol_r <= cpol;
      sclk <= cpol;
      repeat (HALF) @(posedge clock);
      select_n <= 1'b0;
      repeat (HALF) @(posedge clock);
   end
   endtask
   task automatic shift(input logic [7:0] tx, input int n, output logic [7:0] rx);
      int i;
   begin
      rx = 8'h00;
      for (i = 0; i < n; i++)
      begin
         sclk <= 1'b0;
         mosi <= tx[7 - i];
         repeat (HALF) @(posedge clock);
         sclk <= 1'b1;
         rx = {rx[6:0], miso};
         repeat (HALF) @(posedge clock);
      end
   end
   endtask
   task automatic finish;
   begin
      sclk <= cpol_r;
      repeat (HALF) @(posedge clock);
      select_n <= 1'b1;
      // Released line shows the inverse so a stale level cannot pass
      mosi <= ~mosi;
      repeat (HALF) @(posedge clock);
   end
   endtask
endmodule // host_model
`default_nettype wire

// >>> testbench/spi_front_end_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module spi_front_end_tb_top;
   logic clock = 1'b0, sys_rst = 1'b1, hw_reset_n_pin = 1'b1, flip = 1'b0, guard_pin = 1'b1;
   logic quad_lane_enable_bit = 1'b0, guard_enable_bit = 1'b0;
   logic pause_pin = 1'b1;
   logic dtr_enable_bit = 1'b0;
   logic [3:0] block_guard_field = 4'h0;
   logic [1:0] status_guard_field = 2'h0;
   logic [7:0] read_data = 8'h00, last_op = 8'h00, last_rx = 8'h00;
   logic sclk_pin, select_n_pin, mosi, lane_zero_out, lane_zero_oe, lane_one_out, lane_one_oe;
   logic lane_two_out, lane_two_oe, lane_three_out, lane_three_oe, read_data_take, opcode_valid;
   logic rx_byte_valid, quad_rejected, array_write_block, prot_reg_write_block, paused, in_reset;
   logic [7:0] opcode, rx_byte;
   logic [3:0] protected_blocks_code;
   int err_count = 0, checked = 0, op_cnt = 0;
   // Undriven serial output toggles so the host never reads a stale level
   wire logic lane_zero_in = lane_zero_oe ? lane_zero_out : mosi;
   wire logic lane_one_in = lane_one_oe ? lane_one_out : flip;
   wire logic lane_two_in = lane_two_oe ? lane_two_out : guard_pin;
   wire logic lane_three_in = lane_three_oe ? lane_three_out : pause_pin;
   wire logic [7:0] oe4 = {4'h0, lane_three_oe, lane_two_oe, lane_one_oe, lane_zero_oe};
   always #5 clock = ~clock;
   always @(posedge clock)
   begin
      flip <= ~flip;
      if (opcode_valid === 1'b1)
      begin
         op_cnt <= op_cnt + 1;
         last_op <= opcode;
      end
      if (rx_byte_valid === 1'b1)
         last_rx <= rx_byte;
   end
   host_model host (.clock, .sclk(sclk_pin), .select_n(select_n_pin), .mosi, .miso(lane_one_in));
   spi_front_end #(.RESET_MIN_CYC(4)) spi_front_end_i (.clock, .sys_rst, .sclk_pin, .select_n_pin,
      .hw_reset_n_pin, .lane_zero_in, .lane_zero_out, .lane_zero_oe, .lane_one_in, .lane_one_out,
      .lane_one_oe, .lane_two_in, .lane_two_out, .lane_two_oe, .lane_three_in, .lane_three_out,
      .lane_three_oe, .quad_lane_enable_bit, .guard_enable_bit, .dtr_enable_bit, .block_guard_field,
      .status_guard_field, .read_data, .read_data_take, .opcode, .opcode_valid, .rx_byte, .rx_byte_valid,
      .quad_rejected, .protected_blocks_code, .array_write_block, .prot_reg_write_block, .paused, .in_reset);
   task automatic idle(input int n);
      repeat (n) @(posedge clock);
   endtask
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
   begin
      checked++;
      if (got !== exp)
      begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   end
   endtask
   task automatic head(input logic cpol);
      logic [7:0] r;
   begin
      host.start(cpol);
      host.shift(8'h0b, 8, r);
      host.shift(8'h12, 8, r);
      host.shift(8'h34, 8, r);
   end
   endtask
   task automatic t_no_select;
      logic [7:0] r;
   begin
      host.shift(8'h0b, 8, r);
      host.finish();
      chk("opcode count", 8'h00, op_cnt[7:0]);
      chk("lane drive", 8'h00, oe4);
      $display("test no_select done");
   end
   endtask
   task automatic t_read;
      logic [7:0] r;
      int m;
   begin
      for (m = 0; m < 2; m++)
      begin
         read_data <= 8'hc6 ^ m[7:0];
         head(m[0]);
         host.shift(8'h00, 8, r);
         chk("opcode", 8'h0b, last_op);
         chk("address", 8'h34, last_rx);
         chk("read data", 8'hc6 ^ m[7:0], r);
         host.finish();
         idle(6);
         chk("lane drive", 8'h00, oe4);
      end
      $display("test read done");
   end
   endtask
   task automatic t_abort;
      logic [7:0] r;
      int c;
   begin
      c = op_cnt;
      host.start(1'b0);
      host.shift(8'hb0, 4, r);
      host.finish();
      host.start(1'b0);
      host.shift(8'h05, 8, r);
      host.finish();
      chk("opcode count", 8'h01, 8'(op_cnt - c));
      chk("opcode", 8'h05, last_op);
      $display("test abort done");
   end
   endtask
   task automatic t_lanes;
      logic [7:0] r;
      int k;
   begin
      for (k = 0; k < 3; k++)
      begin
         quad_lane_enable_bit <= (k != 0);
         guard_enable_bit <= (k == 2);
         host.start(1'b0);
         host.shift((k == 0) ? 8'h3b : 8'h6b, 8, r);
         chk("quad refused", {7'h0, k == 2}, {7'h0, quad_rejected});
         host.shift(8'h00, 8, r);
         host.shift(8'h00, 8, r);
         host.shift(8'h00, 2, r);
         chk("lane drive", (k == 0) ? 8'h03 : (k == 1) ? 8'h0f : 8'h00, oe4);
         host.finish();
         idle(6);
         chk("refusal cleared", 8'h00, {7'h0, quad_rejected});
      end
      quad_lane_enable_bit <= 1'b0;
      guard_enable_bit <= 1'b0;
      $display("test lanes done");
   end
   endtask
   task automatic t_guard;
      int k;
   begin
      for (k = 0; k < 16; k++)
      begin
         quad_lane_enable_bit <= k[0];
         guard_enable_bit <= k[1];
         guard_pin <= k[2];
         status_guard_field <= {1'b0, k[3]};
         block_guard_field <= k[3:0];
         idle(6);
         chk("array block", {7'h0, k[1] & ~k[0] & ~k[2]}, {7'h0, array_write_block});
         chk("reg block", {7'h0, ~k[0] & ~k[2] & (k[1] | k[3])}, {7'h0, prot_reg_write_block});
         chk("block field", {4'h0, k[3:0]}, {4'h0, protected_blocks_code});
      end
      {quad_lane_enable_bit, guard_enable_bit, guard_pin} <= 3'b001;
      $display("test guard done");
   end
   endtask
   task automatic t_stall;
      logic [7:0] r;
   begin
      head(1'b0);
      host.shift(8'h00, 1, r);
      pause_pin <= 1'b0;
      idle(6);
      chk("pause with clock high", 8'h00, {7'h0, paused});
      host.sclk <= 1'b0;
      idle(6);
      chk("pause", 8'h01, {7'h0, paused});
      chk("lane drive in pause", 8'h00, oe4);
      pause_pin <= 1'b1;
      idle(6);
      chk("resume", 8'h02, oe4);
      hw_reset_n_pin <= 1'b0;
      idle(12);
      chk("hardware reset", 8'h01, {7'h0, in_reset});
      chk("lane drive in reset", 8'h00, oe4);
      hw_reset_n_pin <= 1'b1;
      idle(6);
      chk("reset released", 8'h00, {7'h0, in_reset});
      host.finish();
      $display("test stall done");
   end
   endtask
   task automatic t_dtr;
      logic [7:0] r;
   begin
      dtr_enable_bit <= 1'b1;
      head(1'b0);
      pause_pin <= 1'b0;
      host.shift(8'h00, 2, r);
      chk("pause with double-edge", 8'h00, {7'h0, paused});
      pause_pin <= 1'b1;
      host.finish();
      dtr_enable_bit <= 1'b0;
      $display("test dtr done");
   end
   endtask
   task automatic conclude;
   begin
      $display("Counts: %0d compares, %0d mismatches", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   end
   endtask
   initial
   begin
      idle(20000);
      err_count++;
      $display("MISMATCH watchdog expected finish seen timeout");
      conclude;
   end
   initial
   begin
      idle(6);
      sys_rst <= 1'b0;
      idle(4);
      t_no_select;
      t_read;
      t_abort;
      t_lanes;
      t_guard;
      t_stall;
      t_dtr;
      conclude;
   end
endmodule // spi_front_end_tb_top
`default_nettype wire
